// ---- hw/timer_f_flag_control.sv ----
// Paired 8-bit timer: counters, compare match, overflow flags, interrupts.
// Assumes an AXI4-Lite master on aclk and one system clock throughout.
`timescale 1ns/1ps
module timer_f_flag_control (
    input  wire logic        aclk,     // System clock, 10 MHz.
    input  wire logic        aresetn,  // Synchronous reset, active low.
    input  wire logic        ce,       // Clock enable; low freezes state.
    input  wire logic [7:0]  awaddr,   // Write address.
    input  wire logic        awvalid,  // Write address valid.
    output logic             awready,  // Write address ready.
    input  wire logic [31:0] wdata,    // Write data.
    input  wire logic [3:0]  wstrb,    // Write byte strobes.
    input  wire logic        wvalid,   // Write data valid.
    output logic             wready,   // Write data ready.
    output logic [1:0]       bresp,    // Write response.
    output logic             bvalid,   // Write response valid.
    input  wire logic        bready,   // Write response ready.
    input  wire logic [7:0]  araddr,   // Read address.
    input  wire logic        arvalid,  // Read address valid.
    output logic             arready,  // Read address ready.
    output logic [31:0]      rdata,    // Read data.
    output logic [1:0]       rresp,    // Read response.
    output logic             rvalid,   // Read data valid.
    input  wire logic        rready,   // Read data ready.
    output logic             irq       // Level interrupt request.
);
    logic [7:0]  cs_r, cs_nxt;
    logic [3:0]  arm_r, arm_nxt;
    logic [7:0]  low_cnt_r, low_cnt_nxt, high_cnt_r, high_cnt_nxt;
    logic [7:0]  low_cmp_r, low_cmp_nxt, high_cmp_r, high_cmp_nxt;
    logic [1:0]  mode_r, mode_nxt;
    logic [3:0]  ist_r, ist_nxt, imask_r, imask_nxt;
    logic        aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic [7:0]  aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic        w_strb_r, w_strb_nxt;
    logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        wr_go, rd_go, cs_wr, cs_rd, wr_hit, rd_hit;
    logic        run, low_hit, low_wrap, high_tick, high_hit, high_wrap;

    // Only one write is in flight; address and data may arrive in any order.
    assign awready = ~aw_held_r;
    assign wready  = ~w_held_r;
    assign arready = ~rvalid_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign rvalid  = rvalid_r;
    assign rresp   = rresp_r;
    assign rdata   = rdata_r;
    assign irq     = |(ist_r & imask_r);

    // Decode of the bus side; bits 1:0 of addresses are ignored.
    always_comb begin
        wr_go  = aw_held_r & w_held_r & ~bvalid_r;
        rd_go  = arvalid & ~rvalid_r;
        wr_hit = (aw_addr_r <= timer_f_pkg::IRQ_MASK_OFS + 8'h03);
        rd_hit = (araddr <= timer_f_pkg::IRQ_MASK_OFS + 8'h03);
        cs_wr  = wr_go & w_strb_r
               & (aw_addr_r[7:2] == timer_f_pkg::CTRL_STATUS_OFS[7:2]);
        cs_rd  = rd_go
               & (araddr[7:2] == timer_f_pkg::CTRL_STATUS_OFS[7:2]);
    end

    // Count events; a compare hit with clear selected restarts at zero.
    always_comb begin
        run       = mode_r[timer_f_pkg::RUN_BIT];
        low_hit   = run & (low_cnt_r == low_cmp_r);
        low_wrap  = run & (low_cnt_r == timer_f_pkg::COUNT_MAX)
                  & ~(low_hit & cs_r[timer_f_pkg::LOW_CCLR_BIT]);
        // In sixteen-bit mode the high half ticks on low overflow.
        high_tick = mode_r[timer_f_pkg::MODE16_BIT] ? low_wrap : run;
        high_hit  = high_tick & (high_cnt_r == high_cmp_r);
        high_wrap = high_tick & (high_cnt_r == timer_f_pkg::COUNT_MAX)
                  & ~(high_hit & cs_r[timer_f_pkg::HIGH_CCLR_BIT]);
        low_cnt_nxt = low_cnt_r;
        if (run) begin
            low_cnt_nxt = (low_hit & cs_r[timer_f_pkg::LOW_CCLR_BIT])
                        ? 8'h00 : low_cnt_r + 8'h01;
        end
        high_cnt_nxt = high_cnt_r;
        if (high_tick) begin
            high_cnt_nxt = (high_hit & cs_r[timer_f_pkg::HIGH_CCLR_BIT])
                         ? 8'h00 : high_cnt_r + 8'h01;
        end
    end

    // Registers and flags. A flag clears only by a zero written after a
    // read that saw it set; an event in the same cycle still wins.
    always_comb begin
        cs_nxt    = cs_r;
        arm_nxt   = arm_r;
        low_cmp_nxt  = low_cmp_r;
        high_cmp_nxt = high_cmp_r;
        mode_nxt  = mode_r;
        ist_nxt   = ist_r;
        imask_nxt = imask_r;
        if (cs_wr) begin
            cs_nxt[timer_f_pkg::HIGH_OVIE_BIT] =
                w_data_r[timer_f_pkg::HIGH_OVIE_BIT];
            cs_nxt[timer_f_pkg::HIGH_CCLR_BIT] =
                w_data_r[timer_f_pkg::HIGH_CCLR_BIT];
            cs_nxt[timer_f_pkg::LOW_OVIE_BIT] =
                w_data_r[timer_f_pkg::LOW_OVIE_BIT];
            cs_nxt[timer_f_pkg::LOW_CCLR_BIT] =
                w_data_r[timer_f_pkg::LOW_CCLR_BIT];
            // Writing one to a flag does nothing.
            if (arm_r[0] && !w_data_r[timer_f_pkg::LOW_MATCH_BIT])
                cs_nxt[timer_f_pkg::LOW_MATCH_BIT] = 1'b0;
            if (arm_r[1] && !w_data_r[timer_f_pkg::LOW_OVF_BIT])
                cs_nxt[timer_f_pkg::LOW_OVF_BIT] = 1'b0;
            if (arm_r[2] && !w_data_r[timer_f_pkg::HIGH_MATCH_BIT])
                cs_nxt[timer_f_pkg::HIGH_MATCH_BIT] = 1'b0;
            if (arm_r[3] && !w_data_r[timer_f_pkg::HIGH_OVF_BIT])
                cs_nxt[timer_f_pkg::HIGH_OVF_BIT] = 1'b0;
            arm_nxt = 4'h0;
        end
        if (cs_rd) begin
            arm_nxt = arm_nxt | {cs_r[timer_f_pkg::HIGH_OVF_BIT],
                                 cs_r[timer_f_pkg::HIGH_MATCH_BIT],
                                 cs_r[timer_f_pkg::LOW_OVF_BIT],
                                 cs_r[timer_f_pkg::LOW_MATCH_BIT]};
        end
        if (wr_go && w_strb_r) begin
            case (aw_addr_r[7:2])
                timer_f_pkg::LOW_CMP_OFS[7:2]:  low_cmp_nxt = w_data_r[7:0];
                timer_f_pkg::HIGH_CMP_OFS[7:2]: high_cmp_nxt = w_data_r[7:0];
                timer_f_pkg::MODE_OFS[7:2]:     mode_nxt = w_data_r[1:0];
                timer_f_pkg::IRQ_MASK_OFS[7:2]: imask_nxt = w_data_r[3:0];
                default: ;
            endcase
        end
        if (rd_go && araddr[7:2] == timer_f_pkg::IRQ_STATUS_OFS[7:2])
            ist_nxt = 4'h0;
        if (low_hit) cs_nxt[timer_f_pkg::LOW_MATCH_BIT] = 1'b1;
        if (low_wrap) cs_nxt[timer_f_pkg::LOW_OVF_BIT] = 1'b1;
        if (high_hit) cs_nxt[timer_f_pkg::HIGH_MATCH_BIT] = 1'b1;
        if (high_wrap) cs_nxt[timer_f_pkg::HIGH_OVF_BIT] = 1'b1;
        // Overflow requests need their enable, seen at the event.
        if (low_wrap && cs_r[timer_f_pkg::LOW_OVIE_BIT])
            ist_nxt[timer_f_pkg::IRQ_LOW_OVF] = 1'b1;
        if (high_wrap && cs_r[timer_f_pkg::HIGH_OVIE_BIT])
            ist_nxt[timer_f_pkg::IRQ_HIGH_OVF] = 1'b1;
        if (low_hit) ist_nxt[timer_f_pkg::IRQ_LOW_MATCH] = 1'b1;
        if (high_hit) ist_nxt[timer_f_pkg::IRQ_HIGH_MATCH] = 1'b1;
    end

    // Bus handshake state and read data.
    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt  = w_held_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r & ~bready;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r & ~rready;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        if (awvalid && !aw_held_r) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = awaddr;
        end
        if (wvalid && !w_held_r) begin
            w_held_nxt = 1'b1;
            w_data_nxt = wdata;
            w_strb_nxt = wstrb[0];
        end
        if (wr_go) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_hit ? timer_f_pkg::RESP_OKAY
                                 : timer_f_pkg::RESP_SLVERR;
        end
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = rd_hit ? timer_f_pkg::RESP_OKAY
                                : timer_f_pkg::RESP_SLVERR;
            case (araddr[7:2])
                timer_f_pkg::CTRL_STATUS_OFS[7:2]: rdata_nxt = {24'h0, cs_r};
                timer_f_pkg::LOW_CMP_OFS[7:2]:  rdata_nxt = {24'h0, low_cmp_r};
                timer_f_pkg::HIGH_CMP_OFS[7:2]: rdata_nxt = {24'h0, high_cmp_r};
                timer_f_pkg::COUNTERS_OFS[7:2]:
                    rdata_nxt = {16'h0, high_cnt_r, low_cnt_r};
                timer_f_pkg::MODE_OFS[7:2]:     rdata_nxt = {30'h0, mode_r};
                timer_f_pkg::IRQ_STATUS_OFS[7:2]: rdata_nxt = {28'h0, ist_r};
                timer_f_pkg::IRQ_MASK_OFS[7:2]: rdata_nxt = {28'h0, imask_r};
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    // All state; clock enable low holds everything, bus included.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cs_r <= timer_f_pkg::CTRL_STATUS_RST;
            arm_r <= 4'h0;
            low_cnt_r <= 8'h00;
            high_cnt_r <= 8'h00;
            low_cmp_r <= timer_f_pkg::CMP_RST;
            high_cmp_r <= timer_f_pkg::CMP_RST;
            mode_r <= timer_f_pkg::MODE_RST;
            ist_r <= timer_f_pkg::IRQ_RST;
            imask_r <= timer_f_pkg::IRQ_RST;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0;
            w_strb_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= timer_f_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= timer_f_pkg::RESP_OKAY;
            rdata_r <= 32'h0;
        end else if (ce) begin
            cs_r <= cs_nxt;
            arm_r <= arm_nxt;
            low_cnt_r <= low_cnt_nxt;
            high_cnt_r <= high_cnt_nxt;
            low_cmp_r <= low_cmp_nxt;
            high_cmp_r <= high_cmp_nxt;
            mode_r <= mode_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Checks on flag and counter behaviour.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    low_ovf_irq_a: assert property ($rose(ist_r[0]) |-> $past(cs_r[1]))
        else $error("Low overflow request without enable.");
    low_match_set_a: assert property (ce && low_hit |=> cs_r[2])
        else $error("Low match flag not set on match.");
    low_match_clr_a: assert property
        ($fell(cs_r[2]) |-> $past(cs_wr && arm_r[0] && !w_data_r[2]))
        else $error("Low match flag cleared without read then zero.");
    low_ovf_set_a: assert property
        (ce && run && low_cnt_r == 8'hff && !cs_r[0] |=> cs_r[3])
        else $error("Low overflow flag not set on wrap.");
    low_ovf_clr_a: assert property
        ($fell(cs_r[3]) |-> $past(cs_wr && arm_r[1] && !w_data_r[3]))
        else $error("Low overflow flag cleared without read then zero.");
    high_match_clr_a: assert property
        ($fell(cs_r[6]) |-> $past(cs_wr && arm_r[2] && !w_data_r[6]))
        else $error("High match flag cleared without read then zero.");
    high_ovf_flag_a: assert property
        (ce && high_wrap |=> cs_r[7] ##0 high_cnt_r == 8'h00)
        else $error("High overflow flag or wrap wrong.");
    mode16_hold_a: assert property
        (ce && mode_r == 2'h3 && !low_wrap |=> $stable(high_cnt_r))
        else $error("High half moved without low overflow.");
    high_match_set_a: assert property (ce && high_hit |=> cs_r[6])
        else $error("High match flag not set on match.");
    flag_cleared_c: cover property ($fell(cs_r[3]));
    mode16_carry_c: cover property (mode_r == 2'h3 && low_wrap);
    irq_raised_c: cover property ($rose(irq));
endmodule : timer_f_flag_control

// ---- hw/timer_f_pkg.sv ----
// Constants for the paired 8-bit timer flag and control block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package timer_f_pkg;
    // Register byte offsets.
    localparam logic [7:0] CTRL_STATUS_OFS = 8'h00;
    localparam logic [7:0] LOW_CMP_OFS     = 8'h04;
    localparam logic [7:0] HIGH_CMP_OFS    = 8'h08;
    localparam logic [7:0] COUNTERS_OFS    = 8'h0c;
    localparam logic [7:0] MODE_OFS        = 8'h10;
    localparam logic [7:0] IRQ_STATUS_OFS  = 8'h14;
    localparam logic [7:0] IRQ_MASK_OFS    = 8'h18;

    // Field positions in the control and status register.
    localparam int HIGH_OVF_BIT   = 7;
    localparam int HIGH_MATCH_BIT = 6;
    localparam int HIGH_OVIE_BIT  = 5;
    localparam int HIGH_CCLR_BIT  = 4;
    localparam int LOW_OVF_BIT    = 3;
    localparam int LOW_MATCH_BIT  = 2;
    localparam int LOW_OVIE_BIT   = 1;
    localparam int LOW_CCLR_BIT   = 0;

    // Field positions in the mode register.
    localparam int RUN_BIT    = 0;
    localparam int MODE16_BIT = 1;

    // Field positions in the interrupt status and mask registers.
    localparam int IRQ_LOW_OVF    = 0;
    localparam int IRQ_LOW_MATCH  = 1;
    localparam int IRQ_HIGH_OVF   = 2;
    localparam int IRQ_HIGH_MATCH = 3;

    // Reset values and counter limits.
    localparam logic [7:0] CTRL_STATUS_RST = 8'h00;
    localparam logic [7:0] CMP_RST         = 8'hff;
    localparam logic [7:0] COUNT_MAX       = 8'hff;
    localparam logic [1:0] MODE_RST        = 2'h0;
    localparam logic [3:0] IRQ_RST         = 4'h0;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : timer_f_pkg

// ---- bench/tb_top.sv ----
// Self-checking bench for the paired 8-bit timer flag and control block.
// Assumes the design package is compiled first. Bus readies are looked at
// on the falling edge, where they already hold their next-edge value.
`timescale 1ns/1ps
`define chk(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h expected %h", $time, a, e); end end
module tb_top;
    logic        aclk, aresetn, ce, awvalid, wvalid, bready;
    logic        arvalid, rready, awready, wready, bvalid, arready;
    logic        rvalid, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          error_cnt, comparisons;

    timer_f_flag_control u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .irq(irq));

    // Free-running 10 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // Expected interrupt status after a long run: both matches always fire,
    // an overflow only shows when its enable was set at the wrap.
    function automatic logic [31:0] exp_irq(input logic lo_en, hi_en);
        return {28'h0, 1'b1, hi_en, 1'b1, lo_en};
    endfunction : exp_irq

    // Holds reset low for six edges; the reset is synchronous.
    task automatic reset_dut();
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : reset_dut

    // One write; bready stays high, so the response is taken when it shows.
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic ta, tw, tb;
        logic [1:0] br;
        n = 0;
        tb = 1'b0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!tb && n < 100) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            br = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end
        if (!tb) begin
            error_cnt++;
            results();
        end
        `chk(br, timer_f_pkg::RESP_OKAY)
    endtask : bus_wr

    // One read; the data and response are taken with rvalid.
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int   n;
        logic ta, tr;
        n = 0;
        tr = 1'b0;
        araddr  <= a;
        arvalid <= 1'b1;
        while (!tr && n < 100) begin
            @(negedge aclk);
            ta = arvalid & arready;
            tr = rvalid;
            d  = rdata;
            r  = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            n++;
        end
        if (!tr) begin
            error_cnt++;
            results();
        end
    endtask : bus_rd

    // The irq output is decoded from registered status and mask; give it two edges to follow.
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        `chk(irq, e)
        @(posedge aclk);
    endtask : chk_irq

    // Runs the counters long enough for every low counter value to pass once.
    task automatic run_long(input logic [31:0] mode_on, mode_off);
        bus_wr(timer_f_pkg::MODE_OFS, mode_on);
        repeat (300) @(posedge aclk);
        bus_wr(timer_f_pkg::MODE_OFS, mode_off);
    endtask : run_long

    // Main sequence: reset values, flag setting and clearing, irq, mode16.
    initial begin
        logic [7:0]  ofs [7];
        logic [31:0] rst [7];
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  lc, hc;
        ofs = '{timer_f_pkg::CTRL_STATUS_OFS, timer_f_pkg::LOW_CMP_OFS,
                timer_f_pkg::HIGH_CMP_OFS, timer_f_pkg::COUNTERS_OFS,
                timer_f_pkg::MODE_OFS, timer_f_pkg::IRQ_STATUS_OFS,
                timer_f_pkg::IRQ_MASK_OFS};
        rst = '{{24'h0, timer_f_pkg::CTRL_STATUS_RST},
                {24'h0, timer_f_pkg::CMP_RST}, {24'h0, timer_f_pkg::CMP_RST},
                32'h0, {30'h0, timer_f_pkg::MODE_RST},
                {28'h0, timer_f_pkg::IRQ_RST}, {28'h0, timer_f_pkg::IRQ_RST}};
        ce = 1'b1;
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        bready = 1'b1;
        rready = 1'b1;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        error_cnt = 0;
        comparisons = 0;
        void'($urandom(32'hb0c3));
        reset_dut();
        for (int i = 0; i < 7; i++) begin
            bus_rd(ofs[i], d, r);
            `chk(d, rst[i])
        end
        bus_rd(8'h20, d, r);
        `chk(r, timer_f_pkg::RESP_SLVERR)
        `chk(d, 32'h0)
        // Random compare values: a 300-tick run meets any of them.
        lc = 8'($urandom);
        hc = 8'($urandom);
        bus_wr(timer_f_pkg::LOW_CMP_OFS, {24'h0, lc});
        bus_wr(timer_f_pkg::HIGH_CMP_OFS, {24'h0, hc});
        bus_rd(timer_f_pkg::LOW_CMP_OFS, d, r);
        `chk(d, {24'h0, lc})
        // A write without its low byte strobe must leave the register alone.
        wstrb <= 4'he;
        bus_wr(timer_f_pkg::LOW_CMP_OFS, 32'h0);
        wstrb <= 4'hf;
        bus_rd(timer_f_pkg::LOW_CMP_OFS, d, r);
        `chk(d, {24'h0, lc})
        bus_wr(timer_f_pkg::CTRL_STATUS_OFS, 32'h02);
        bus_wr(timer_f_pkg::IRQ_MASK_OFS, 32'h1);
        run_long(32'h1, 32'h0);
        chk_irq(1'b1);
        bus_rd(timer_f_pkg::IRQ_STATUS_OFS, d, r);
        `chk(d, exp_irq(1'b1, 1'b0))
        chk_irq(1'b0);
        // A clearing write without the arming read leaves flags set.
        bus_wr(timer_f_pkg::CTRL_STATUS_OFS, 32'h02);
        bus_rd(timer_f_pkg::CTRL_STATUS_OFS, d, r);
        `chk(d, 32'hce)
        bus_wr(timer_f_pkg::CTRL_STATUS_OFS, 32'h02);
        bus_rd(timer_f_pkg::CTRL_STATUS_OFS, d, r);
        `chk(d, 32'h02)
        bus_wr(timer_f_pkg::CTRL_STATUS_OFS, 32'hce);
        bus_rd(timer_f_pkg::CTRL_STATUS_OFS, d, r);
        `chk(d, 32'h02)
        // Enables off: flags still set, overflow requests stay quiet.
        bus_wr(timer_f_pkg::CTRL_STATUS_OFS, 32'h00);
        bus_wr(timer_f_pkg::IRQ_MASK_OFS, 32'h5);
        run_long(32'h1, 32'h0);
        chk_irq(1'b0);
        bus_rd(timer_f_pkg::IRQ_STATUS_OFS, d, r);
        `chk(d, exp_irq(1'b0, 1'b0))
        bus_rd(timer_f_pkg::CTRL_STATUS_OFS, d, r);
        `chk(d, 32'hcc)
        // Sixteen-bit mode: about 300 ticks give exactly one carry.
        reset_dut();
        run_long(32'h3, 32'h2);
        bus_rd(timer_f_pkg::COUNTERS_OFS, d, r);
        `chk(d[15:8], 8'h01)
        `chk(d[7:0], 8'h2f)
        // Clock enable low for 50 edges: only three ticks land in all.
        bus_wr(timer_f_pkg::MODE_OFS, 32'h1);
        ce <= 1'b0;
        repeat (50) @(posedge aclk);
        ce <= 1'b1;
        bus_wr(timer_f_pkg::MODE_OFS, 32'h0);
        bus_rd(timer_f_pkg::COUNTERS_OFS, d, r);
        `chk(d, 32'h432)
        results();
    end
endmodule : tb_top
